// *** core/triple_interval_timer.sv ***
/*
 Three-channel interval timer: byte-wide register port, three counters,
 counter 0 clock selection and the cascaded 32-bit pacer on counters 1 and 2.
 Assumes a 20 MHz REF_CLK and one register access per cycle at most.
*/
// Notes on behaviour
// - Three 16-bit down-counters, counts 2..65535.
// - Counters 0 and 1 tick at 10 MHz from board clock; counter 2 ticks on counter 1 output rises.
// - Counter 0 internal timer or external event counter.
// - In modes 0, 2, 3 and 4 counter 0 counts only while its gate is high.
// - Counters 1 and 2 chain into 32 bits.
// - Counter 2 rising output starts conversion, exported.
// - Data ports at 24,26,28; control at 30.
// - Control word fields: select, format, mode, decimal.
// - Select codes 0..2 pick counter; 3 reads back.
// - Format: latch, low only, high only, both.
// - Mode codes 0..5, top bit ignored for 2/3.
// - Decimal bit chooses binary or BCD counting.
// - Read-back bits choose count, status, counters.
// - Status byte: output, null flag, programmed fields.
// - Mode 0 low until terminal count; rewrite restarts.
// - Mode 1 retriggerable one-shot from gate edge.
// - Mode 3 odd counts split (N+1)/2, (N-1)/2.
// - Latch command holds count without stopping counting.
`default_nettype none

module timer_channel (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic gate,
   input wire logic ctl_wr,
   input wire triple_timer_pkg::ctl_word_t ctl,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] wdata,
   input wire logic latch_count,
   input wire logic latch_status,
   output logic [7:0] rdata,
   output logic out
);
   logic [1:0] fmt;
   logic [2:0] mode_raw;
   logic bcd;
   logic [15:0] hold_reg;
   logic [15:0] ce;
   logic [15:0] held_count;
   logic [7:0] status;
   logic wr_hi;
   logic rd_hi;
   logic count_held;
   logic status_held;
   logic null_count;
   logic load_pend;
   logic run;
   logic trig;
   logic first;
   logic gate_q;
   triple_timer_pkg::mode_t mode;
   logic gate_rise;
   logic byte_first;
   logic count_done;
   logic at_one;
   logic at_two;
   logic periodic;
   logic [1:0] step;
   logic [15:0] nx;
   logic [15:0] src;
   logic pick_high;

   // Mode bits are kept raw so read-back shows exactly what was written.
   assign mode = triple_timer_pkg::mode_of(mode_raw);
   assign gate_rise = gate & ~gate_q;
   assign byte_first = data_wr & (fmt == triple_timer_pkg::FMT_BOTH) & ~wr_hi;
   assign count_done = data_wr & ~byte_first;
   assign at_one = (ce == triple_timer_pkg::COUNT_ONE);
   assign at_two = (ce == triple_timer_pkg::COUNT_TWO);
   assign periodic = (mode == triple_timer_pkg::MODE_RATE) |
                     (mode == triple_timer_pkg::MODE_SQUARE);
   // Odd counts take one extra step high and one short step low.
   assign step = (first & hold_reg[0]) ?
                 (out ? triple_timer_pkg::STEP_ONE :
                        triple_timer_pkg::STEP_THREE) :
                 triple_timer_pkg::STEP_TWO;
   assign nx = triple_timer_pkg::dec_step(ce, bcd,
      (mode == triple_timer_pkg::MODE_SQUARE) ? step :
      triple_timer_pkg::STEP_ONE);
   assign src = count_held ? held_count : ce;
   assign pick_high = (fmt == triple_timer_pkg::FMT_HIGH) |
                      ((fmt == triple_timer_pkg::FMT_BOTH) & rd_hi);
   assign rdata = status_held ? status :
                  (pick_high ? src[15:8] : src[7:0]);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gate_q <= 1'b1;
      end else begin
         gate_q <= gate;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fmt <= triple_timer_pkg::FMT_BOTH;
         mode_raw <= triple_timer_pkg::MODE_RAW_RESET;
         bcd <= 1'b0;
         hold_reg <= triple_timer_pkg::COUNT_ZERO;
         wr_hi <= 1'b0;
      end else if (ctl_wr) begin
         fmt <= ctl.fmt;
         mode_raw <= ctl.mode;
         bcd <= ctl.bcd;
         wr_hi <= 1'b0;
      end else if (data_wr) begin
         unique case (fmt)
            triple_timer_pkg::FMT_LOW: begin
               hold_reg <= {triple_timer_pkg::BYTE_ZERO, wdata};
            end
            triple_timer_pkg::FMT_HIGH: begin
               hold_reg <= {wdata, triple_timer_pkg::BYTE_ZERO};
            end
            default: begin
               if (wr_hi) begin
                  hold_reg[15:8] <= wdata;
               end else begin
                  hold_reg[7:0] <= wdata;
               end
               wr_hi <= ~wr_hi;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         held_count <= triple_timer_pkg::COUNT_ZERO;
         status <= triple_timer_pkg::STATUS_RESET;
         count_held <= 1'b0;
         status_held <= 1'b0;
         rd_hi <= 1'b0;
      end else if (ctl_wr) begin
         count_held <= 1'b0;
         status_held <= 1'b0;
         rd_hi <= 1'b0;
      end else begin
         // A second latch before the first is read keeps the older value.
         if (latch_count & ~count_held) begin
            held_count <= ce;
            count_held <= 1'b1;
         end
         if (latch_status & ~status_held) begin
            status <= {out, null_count, fmt, mode_raw, bcd};
            status_held <= 1'b1;
         end
         if (data_rd) begin
            if (status_held) begin
               status_held <= 1'b0;
            end else if (fmt == triple_timer_pkg::FMT_BOTH) begin
               rd_hi <= ~rd_hi;
               if (rd_hi) begin
                  count_held <= 1'b0;
               end
            end else begin
               count_held <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ce <= triple_timer_pkg::COUNT_ZERO;
         out <= 1'b1;
         run <= 1'b0;
         load_pend <= 1'b0;
         null_count <= 1'b0;
         trig <= 1'b0;
         first <= 1'b0;
      end else if (ctl_wr) begin
         out <= (triple_timer_pkg::mode_of(ctl.mode) ==
                 triple_timer_pkg::MODE_STOP_TC) ? 1'b0 : 1'b1;
         run <= 1'b0;
         load_pend <= 1'b0;
         null_count <= 1'b1;
         trig <= 1'b0;
      end else begin
         if (tick) begin
            trig <= gate_rise;
         end else if (gate_rise) begin
            trig <= 1'b1;
         end
         if (tick) begin
            unique case (mode)
               triple_timer_pkg::MODE_STOP_TC: begin
                  if (load_pend) begin
                     ce <= hold_reg;
                     run <= 1'b1;
                     load_pend <= 1'b0;
                     null_count <= 1'b0;
                  end else if (run & gate) begin
                     ce <= nx;
                     if (at_one) begin
                        out <= 1'b1;
                     end
                  end
               end
               triple_timer_pkg::MODE_ONE_SHOT: begin
                  if (trig) begin
                     ce <= hold_reg;
                     out <= 1'b0;
                     run <= 1'b1;
                     load_pend <= 1'b0;
                     null_count <= 1'b0;
                  end else if (run) begin
                     ce <= nx;
                     if (at_one) begin
                        out <= 1'b1;
                        run <= 1'b0;
                     end
                  end
               end
               triple_timer_pkg::MODE_RATE: begin
                  if ((load_pend & ~run) | trig) begin
                     ce <= hold_reg;
                     run <= 1'b1;
                     out <= 1'b1;
                     load_pend <= 1'b0;
                     null_count <= 1'b0;
                  end else if (run & gate) begin
                     if (at_two) begin
                        out <= 1'b0;
                        ce <= triple_timer_pkg::COUNT_ONE;
                     end else if (at_one) begin
                        out <= 1'b1;
                        ce <= hold_reg;
                        load_pend <= 1'b0;
                        null_count <= 1'b0;
                     end else begin
                        ce <= nx;
                     end
                  end
               end
               triple_timer_pkg::MODE_SQUARE: begin
                  if ((load_pend & ~run) | trig) begin
                     ce <= hold_reg;
                     run <= 1'b1;
                     out <= 1'b1;
                     first <= 1'b1;
                     load_pend <= 1'b0;
                     null_count <= 1'b0;
                  end else if (run & gate) begin
                     if (nx == triple_timer_pkg::COUNT_ZERO) begin
                        out <= ~out;
                        ce <= hold_reg;
                        first <= 1'b1;
                        load_pend <= 1'b0;
                        null_count <= 1'b0;
                     end else begin
                        ce <= nx;
                        first <= 1'b0;
                     end
                  end
               end
               triple_timer_pkg::MODE_SW_STROBE: begin
                  if (~out) begin
                     out <= 1'b1;
                  end
                  if (load_pend) begin
                     ce <= hold_reg;
                     run <= 1'b1;
                     load_pend <= 1'b0;
                     null_count <= 1'b0;
                  end else if (run & gate) begin
                     ce <= nx;
                     if (at_one) begin
                        out <= 1'b0;
                        run <= 1'b0;
                     end
                  end
               end
               triple_timer_pkg::MODE_HW_STROBE: begin
                  if (~out) begin
                     out <= 1'b1;
                  end
                  if (trig) begin
                     ce <= hold_reg;
                     run <= 1'b1;
                     load_pend <= 1'b0;
                     null_count <= 1'b0;
                  end else if (run) begin
                     ce <= nx;
                     if (at_one) begin
                        out <= 1'b0;
                        run <= 1'b0;
                     end
                  end
               end
               default: begin
                  run <= 1'b0;
               end
            endcase
         end
         if (periodic & ~gate) begin
            out <= 1'b1;
         end
         // A write in a tick cycle still marks a pending load.
         if (count_done) begin
            load_pend <= 1'b1;
            null_count <= 1'b1;
            if (mode == triple_timer_pkg::MODE_STOP_TC) begin
               out <= 1'b0;
            end
         end
         if (byte_first & (mode == triple_timer_pkg::MODE_STOP_TC)) begin
            run <= 1'b0;
         end
      end
   end
endmodule

module triple_interval_timer #(
   parameter int unsigned DIV = triple_timer_pkg::DIV_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic [4:0] BUS_ADDR,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   input wire logic [7:0] BUS_WDATA,
   output logic [7:0] BUS_RDATA,
   input wire logic COUNTER0_CLK_EXT_SEL,
   input wire logic COUNTER0_EXT_CLOCK,
   input wire logic COUNTER0_GATE_IN,
   output logic COUNTER0_OUT,
   output logic PACER_OUT,
   output logic AD_CONVERT_START
);
   localparam int unsigned DW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

   logic [DW-1:0] div;
   logic ext_s1;
   logic ext_s2;
   logic ext_s3;
   logic gate_s1;
   logic gate_s2;
   logic out1_q;
   logic out2_q;
   logic tick_int;
   logic ext_edge;
   logic ctl_hit;
   logic [2:0] tick;
   logic [2:0] gate;
   logic [2:0] ctl_wr;
   logic [2:0] data_wr;
   logic [2:0] data_rd;
   logic [2:0] latch_count;
   logic [2:0] latch_status;
   logic [2:0] port_hit;
   logic [2:0] out;
   logic [2:0][7:0] rdata;
   logic [7:0] next_rdata;
   triple_timer_pkg::ctl_word_t ctl;
   logic is_readback;

   assign ctl = BUS_WDATA;
   assign ctl_hit = BUS_WR & (BUS_ADDR ==
                    triple_timer_pkg::OFF_TIMER_CONTROL_WORD);
   assign is_readback = (ctl.pick == triple_timer_pkg::PICK_READBACK);
   assign tick_int = (div == DIV_LAST);
   // The external clock is sampled, so it must stay below half REF_CLK.
   assign ext_edge = ext_s2 & ~ext_s3;
   assign tick[0] = COUNTER0_CLK_EXT_SEL ? ext_edge : tick_int;
   assign tick[1] = tick_int;
   assign tick[2] = out[1] & ~out1_q;
   assign gate[0] = gate_s2;
   assign gate[1] = 1'b1;
   assign gate[2] = 1'b1;
   assign next_rdata = port_hit[0] ? rdata[0] :
                       port_hit[1] ? rdata[1] :
                       port_hit[2] ? rdata[2] : triple_timer_pkg::BYTE_ZERO;

   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_chan
         assign port_hit[i] =
            (BUS_ADDR == triple_timer_pkg::DATA_PORT_OFFSET[i]);
         assign data_wr[i] = BUS_WR & port_hit[i];
         assign data_rd[i] = BUS_RD & port_hit[i];
         assign ctl_wr[i] = ctl_hit & ~is_readback &
                            (ctl.pick == 2'(i)) &
                            (ctl.fmt != triple_timer_pkg::FMT_LATCH);
         // Read-back pick bits are active high and latch bits active low, as coded.
         assign latch_count[i] = ctl_hit & (is_readback ?
            (ctl.mode[i] & ~ctl.fmt[1]) :
            ((ctl.pick == 2'(i)) &
             (ctl.fmt == triple_timer_pkg::FMT_LATCH)));
         assign latch_status[i] = ctl_hit & is_readback &
                                  ctl.mode[i] & ~ctl.fmt[0];
         timer_channel u_chan (
            .clk(REF_CLK),
            .rst(SYS_RST),
            .tick(tick[i]),
            .gate(gate[i]),
            .ctl_wr(ctl_wr[i]),
            .ctl(ctl),
            .data_wr(data_wr[i]),
            .data_rd(data_rd[i]),
            .wdata(BUS_WDATA),
            .latch_count(latch_count[i]),
            .latch_status(latch_status[i]),
            .rdata(rdata[i]),
            .out(out[i])
         );
      end
   endgenerate

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         div <= '0;
      end else if (tick_int) begin
         div <= '0;
      end else begin
         div <= div + DW'(1);
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
         gate_s1 <= 1'b0;
         gate_s2 <= 1'b0;
      end else begin
         ext_s1 <= COUNTER0_EXT_CLOCK;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         gate_s1 <= COUNTER0_GATE_IN;
         gate_s2 <= gate_s1;
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         out1_q <= 1'b1;
         out2_q <= 1'b1;
         AD_CONVERT_START <= 1'b0;
         COUNTER0_OUT <= 1'b1;
         PACER_OUT <= 1'b1;
      end else begin
         out1_q <= out[1];
         out2_q <= out[2];
         AD_CONVERT_START <= out[2] & ~out2_q;
         COUNTER0_OUT <= out[0];
         PACER_OUT <= out[2];
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         BUS_RDATA <= triple_timer_pkg::BYTE_ZERO;
      end else if (BUS_RD) begin
         BUS_RDATA <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// *** pkg/triple_timer_pkg.sv ***
/*
 Constants, control word layout, counting modes and BCD helpers for the
 three-channel interval timer. Assumes byte-wide register accesses.
*/
`default_nettype none
package triple_timer_pkg;
   localparam int unsigned REF_CLK_HZ = 20_000_000;
   localparam int unsigned COUNT_CLK_HZ = 10_000_000;
   localparam int unsigned DIV_CYCLES = REF_CLK_HZ / COUNT_CLK_HZ;
   localparam int unsigned ADDR_W = 5;
   localparam logic [4:0] OFF_TIMER0_DATA_PORT = 5'h18;
   localparam logic [4:0] OFF_TIMER1_DATA_PORT = 5'h1A;
   localparam logic [4:0] OFF_TIMER2_DATA_PORT = 5'h1C;
   localparam logic [4:0] OFF_TIMER_CONTROL_WORD = 5'h1E;
   localparam logic [2:0][4:0] DATA_PORT_OFFSET = {OFF_TIMER2_DATA_PORT,
      OFF_TIMER1_DATA_PORT, OFF_TIMER0_DATA_PORT};
   localparam logic [1:0] PICK_READBACK = 2'h3;
   localparam logic [1:0] FMT_LATCH = 2'h0;
   localparam logic [1:0] FMT_LOW = 2'h1;
   localparam logic [1:0] FMT_HIGH = 2'h2;
   localparam logic [1:0] FMT_BOTH = 2'h3;
   localparam logic [1:0] STEP_ONE = 2'h1;
   localparam logic [1:0] STEP_TWO = 2'h2;
   localparam logic [1:0] STEP_THREE = 2'h3;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [15:0] COUNT_TWO = 16'h0002;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [2:0] MODE_RAW_RESET = 3'h0;

   typedef enum logic [2:0] {
      MODE_STOP_TC = 3'h0,
      MODE_ONE_SHOT = 3'h1,
      MODE_RATE = 3'h2,
      MODE_SQUARE = 3'h3,
      MODE_SW_STROBE = 3'h4,
      MODE_HW_STROBE = 3'h5
   } mode_t;

   typedef struct packed {
      logic [1:0] pick;
      logic [1:0] fmt;
      logic [2:0] mode;
      logic bcd;
   } ctl_word_t;

   function automatic mode_t mode_of(input logic [2:0] raw);
      if (raw[1]) begin
         return mode_t'({1'b0, raw[1:0]});
      end
      return mode_t'(raw);
   endfunction

   function automatic logic [15:0] dec_one(input logic [15:0] v,
                                           input logic bcd);
      logic [15:0] r;
      logic borrow;
      r = v;
      borrow = 1'b1;
      if (!bcd) begin
         r = v - COUNT_ONE;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (borrow) begin
               if (v[4*i +: 4] == 4'h0) begin
                  r[4*i +: 4] = 4'h9;
               end else begin
                  r[4*i +: 4] = v[4*i +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] dec_step(input logic [15:0] v,
                                            input logic bcd,
                                            input logic [1:0] step);
      logic [15:0] r;
      r = v;
      for (int i = 0; i < 3; i++) begin
         if (2'(i) < step) begin
            r = dec_one(r, bcd);
         end
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// *** sim/timer_props.sv ***
/*
 Port checker for triple_interval_timer, bound to every instance.
 Assumes one-cycle bus strobes and the pin lag given by the design.
*/
`default_nettype none
module timer_props #(
   parameter int unsigned DIV = 2
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic [4:0] BUS_ADDR,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   input wire logic [7:0] BUS_WDATA,
   input wire logic [7:0] BUS_RDATA,
   input wire logic COUNTER0_CLK_EXT_SEL,
   input wire logic COUNTER0_EXT_CLOCK,
   input wire logic COUNTER0_GATE_IN,
   input wire logic COUNTER0_OUT,
   input wire logic PACER_OUT,
   input wire logic AD_CONVERT_START
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] c0_mode;
   logic [2:0] gate_low;
   logic [2:0] quiet;
   logic c2_set;
   wire logic ctl_wr = BUS_WR
      && BUS_ADDR == triple_timer_pkg::OFF_TIMER_CONTROL_WORD;
   wire logic c0_ctl = ctl_wr && BUS_WDATA[7:6] == 2'h0
      && BUS_WDATA[5:4] != 2'h0;
   wire logic mapped = BUS_ADDR[4:3] == 2'h3 && !BUS_ADDR[0];
   // Gate sync and pin register lag four cycles, so seven leave margin.
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         c0_mode <= 3'h0;
         gate_low <= 3'h0;
         quiet <= 3'h0;
         c2_set <= 1'b0;
      end else begin
         if (c0_ctl) begin
            c0_mode <= BUS_WDATA[3:1];
         end
         quiet <= c0_ctl ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
         gate_low <= COUNTER0_GATE_IN ? 3'h0
            : gate_low + {2'h0, gate_low != 3'h7};
         c2_set <= c2_set || (ctl_wr && BUS_WDATA[7:6] == 2'h2);
      end
   end
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);
   start_on_rise_a: assert property (
      AD_CONVERT_START |-> PACER_OUT && !$past(PACER_OUT))
      else $error("start pulse without pacer rise");
   rise_gives_start_a: assert property (
      $rose(PACER_OUT) |-> AD_CONVERT_START)
      else $error("pacer rise without start pulse");
   start_single_a: assert property (
      AD_CONVERT_START |=> !AD_CONVERT_START)
      else $error("start pulse longer than one cycle");
   rdata_hold_a: assert property (
      !BUS_RD |=> $stable(BUS_RDATA))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (
      BUS_RD && !mapped |=> BUS_RDATA == 8'h00)
      else $error("unmapped read not zero");
   ctl_read_zero_a: assert property (
      BUS_RD && BUS_ADDR == triple_timer_pkg::OFF_TIMER_CONTROL_WORD
      |=> BUS_RDATA == 8'h00) else $error("control read not zero");
   mode0_low_a: assert property (
      c0_ctl && BUS_WDATA[3:1] == 3'h0 |-> ##[1:4] !COUNTER0_OUT)
      else $error("mode 0 set without low output");
   gate_forces_high_a: assert property (
      c0_mode[1] && gate_low == 3'h7 && quiet == 3'h7 |-> COUNTER0_OUT)
      else $error("closed gate did not hold output high");
   pacer_idle_a: assert property (
      !c2_set |-> PACER_OUT && !AD_CONVERT_START)
      else $error("pacer moved before it was programmed");
endmodule
bind triple_interval_timer timer_props #(.DIV(DIV)) props (
   .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .BUS_ADDR(BUS_ADDR),
   .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_WDATA(BUS_WDATA),
   .BUS_RDATA(BUS_RDATA), .COUNTER0_CLK_EXT_SEL(COUNTER0_CLK_EXT_SEL),
   .COUNTER0_EXT_CLOCK(COUNTER0_EXT_CLOCK),
   .COUNTER0_GATE_IN(COUNTER0_GATE_IN), .COUNTER0_OUT(COUNTER0_OUT),
   .PACER_OUT(PACER_OUT), .AD_CONVERT_START(AD_CONVERT_START));
`default_nettype wire

// *** sim/host_bus.sv ***
/*
 Host software model: byte reads and writes on the register port.
 Assumes the bench calls its tasks one at a time.
*/
`default_nettype none
module host_bus (
   input wire logic clk,
   output logic [4:0] addr,
   output logic wr,
   output logic rd,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      addr = 5'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
   end
   // A released bus shows the inverse of its last value, so a design
   // that samples it outside a strobe cannot match by luck.
   task automatic put(input logic [4:0] a, input logic [7:0] dv);
      @(posedge clk);
      #2;
      addr = a;
      wdata = dv;
      wr = 1'b1;
      @(posedge clk);
      #2;
      wr = 1'b0;
      addr = ~a;
      wdata = ~dv;
   endtask
   task automatic get(input logic [4:0] a, output logic [7:0] dv);
      @(posedge clk);
      #2;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #2;
      rd = 1'b0;
      addr = ~a;
      dv = rdata;
   endtask
   task automatic put16(input logic [4:0] a, input logic [15:0] v);
      put(a, v[7:0]);
      put(a, v[15:8]);
   endtask
   task automatic get16(input logic [4:0] a, output logic [15:0] v);
      get(a, v[7:0]);
      get(a, v[15:8]);
   endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
/*
 Self-checking bench for triple_interval_timer: bus decode, status
 read-back, counting modes, event clock and the cascaded pacer.
 Assumes host_bus drives the port and timer_props is bound.
*/
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DIV = 2;
   localparam int EXT_CYC = 8;
   localparam logic [4:0] CW = triple_timer_pkg::OFF_TIMER_CONTROL_WORD;
   localparam logic [4:0] P0 = triple_timer_pkg::OFF_TIMER0_DATA_PORT;
   localparam logic [4:0] P1 = triple_timer_pkg::OFF_TIMER1_DATA_PORT;
   localparam logic [4:0] P2 = triple_timer_pkg::OFF_TIMER2_DATA_PORT;
   logic clk = 1'b0, rst = 1'b1;
   logic ext_sel = 1'b0, ext_clk = 1'b0, gate = 1'b0;
   logic [4:0] addr;
   logic wr, rd, c0_out, pacer, ad_start, b;
   logic [7:0] wdata, rdata, d;
   logic [15:0] v;
   logic [1:0] f;
   integer seed = 32'h0E0E86CB;
   int err_total = 0;
   int total_checks = 0;
   int cycles = 0, ad_cnt = 0;
   int n, n2, w, hi, lo, i;
   always #25 clk = ~clk;
   always #200 ext_clk = ~ext_clk;
   triple_interval_timer #(.DIV(DIV)) dut (.REF_CLK(clk), .SYS_RST(rst),
      .BUS_ADDR(addr), .BUS_WR(wr), .BUS_RD(rd), .BUS_WDATA(wdata),
      .BUS_RDATA(rdata), .COUNTER0_CLK_EXT_SEL(ext_sel),
      .COUNTER0_EXT_CLOCK(ext_clk), .COUNTER0_GATE_IN(gate),
      .COUNTER0_OUT(c0_out), .PACER_OUT(pacer), .AD_CONVERT_START(ad_start));
   host_bus host (.clk(clk), .addr(addr), .wr(wr), .rd(rd),
      .wdata(wdata), .rdata(rdata));
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(negedge clk) begin
      cycles++;
      if (ad_start === 1'b1) begin
         ad_cnt++;
      end
      if (cycles == 30000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic check(input string what, input logic [31:0] e,
                        input logic [31:0] got);
      total_checks++;
      if (got !== e) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", what, e, got);
      end
   endtask
   function automatic int sq_half(input int cnt, input bit up);
      return (up ? (cnt + 1) / 2 : cnt / 2) * DIV;
   endfunction
   // Counts falling clock edges while the output holds one level.
   task automatic span(input bit s, input logic lvl, output int cnt);
      cnt = 0;
      while ((s ? pacer : c0_out) !== lvl && cnt < 9000) begin
         @(negedge clk);
         cnt++;
      end
      cnt = 0;
      while ((s ? pacer : c0_out) === lvl && cnt < 9000) begin
         @(negedge clk);
         cnt++;
      end
   endtask
   task automatic wave(input bit s);
      span(s, 1'b1, w);
      span(s, 1'b0, w);
      span(s, 1'b1, hi);
      ad_cnt = 0;
      span(s, 1'b0, lo);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #2;
      rst = 1'b0;
      host.get(CW, d);
      check("control read", 8'h00, d);
      host.put(5'h03, 8'h5A);
      host.get(5'h03, d);
      check("unmapped read", 8'h00, d);
      for (int m = 0; m < 8; m++) begin
         i = m % 3;
         f = 2'(1 + {$random(seed)} % 3);
         b = 1'($random(seed));
         host.put(CW, {2'(i), f, 3'(m), b});
         host.put(CW, 8'hE0 | (8'h02 << i));
         host.get(triple_timer_pkg::DATA_PORT_OFFSET[i], d);
         check("status", {m != 0, 1'b1, f, 3'(m), b}, d);
      end
      n = 20 + {$random(seed)} % 41;
      host.put(CW, 8'h34);
      host.put16(P0, 16'(n));
      gate = 1'b1;
      wave(0);
      check("rate high", (n - 1) * DIV, hi);
      check("rate low", DIV, lo);
      host.put(CW, 8'hC2);
      host.get(P0, d);
      check("status first", 7'h34, d[6:0]);
      host.get16(P0, v);
      check("count after status", 1, v >= 1 && v <= n);
      host.put(CW, 8'h00);
      host.get16(P0, v);
      check("latched count", 1, v >= 1 && v <= n);
      gate = 1'b0;
      repeat (10) @(negedge clk);
      check("gate closed", 1'b1, c0_out);
      host.put(CW, 8'h32);
      host.put16(P0, 16'(n));
      gate = 1'b1;
      span(0, 1'b0, w);
      check("one shot low", n * DIV, w);
      for (int k = 0; k < 2; k++) begin
         n = k ? 15 : 3 + 2 * ({$random(seed)} % 20);
         host.put(CW, 8'h36 | 8'(k));
         host.put16(P0, k ? 16'h0015 : 16'(n));
         wave(0);
         check("square high", sq_half(n, 1), hi);
         check("square low", sq_half(n, 0), lo);
      end
      host.put(CW, 8'h30);
      host.put16(P0, 16'h00C8);
      repeat (40) @(negedge clk);
      host.put(P0, 8'h0A);
      repeat (500) @(negedge clk);
      check("first byte stops", 1'b0, c0_out);
      host.put(P0, 8'h00);
      span(0, 1'b0, w);
      check("terminal count", 1, w >= 19 && w <= 26);
      host.put(CW, 8'h36);
      ext_sel = 1'b1;
      host.put16(P0, 16'h0004);
      wave(0);
      check("event period", 4 * EXT_CYC, hi + lo);
      n = 2 + {$random(seed)} % 4;
      n2 = 2 + {$random(seed)} % 6;
      host.put(CW, 8'h74);
      ext_sel = 1'b0;
      host.put16(P1, 16'(n));
      host.put(CW, 8'hB4);
      host.put16(P2, 16'(n2));
      wave(1);
      @(posedge clk);
      #2;
      check("pacer period", n * n2 * DIV, hi + lo);
      check("starts per period", 1, ad_cnt);
      tally_and_finish();
   end
endmodule
`default_nettype wire
